// file: common/i2c_client_pkg.sv
// Purpose: Shared constants and types for the I2C client engine
// Assumes: Byte-wide link, one-hot state codes
// Notes:   Mode field bit 0 picks 10-bit addressing, bit 1 picks condition interrupts
package i2c_client_pkg;
	localparam int          BYTE_W           = 8;
	localparam int          RX_FIFO_DEPTH    = 32;
	localparam logic [3:0]  LAST_DATA_BIT    = 4'h8;
	localparam logic [3:0]  ACK_BIT          = 4'h9;
	localparam logic [3:0]  BITCNT_RESET     = 4'h0;
	localparam logic [4:0]  TEN_BIT_PREFIX   = 5'h1e;
	localparam logic [7:0]  GEN_CALL_ADDR    = 8'h00;
	localparam logic [7:0]  OWN_ADDR_RESET   = 8'h00;
	localparam logic [7:0]  SHIFT_RESET      = 8'h00;
	localparam logic [7:0]  TX_SHIFT_RESET   = 8'hff;
	localparam logic [1:0]  LINE_SYNC_RESET  = 2'h3;
	localparam int          MODE_TEN_BIT     = 0;
	localparam int          MODE_COND_IRQ    = 1;

	typedef enum logic [5:0] {
		st_idle    = 6'h01,
		st_addr    = 6'h02,
		st_addr_lo = 6'h04,
		st_rx      = 6'h08,
		st_tx      = 6'h10,
		st_ignore  = 6'h20
	} client_state_t;
endpackage

// file: src/i2c_client_addressing.sv
// Purpose: I2C client engine with address match, ACK control and clock stretching
// Assumes: SCL and SDA are open-drain pins resolved outside; FIFO depth is a power of two
// Notes:   Received address and data bytes queue in a 32-word FIFO; buffer full means FIFO full
// Notes on behaviour
// - Clearing clock_release grabs SCL only once SCL is seen low; setting releases.
// - Transmitter compares SDA with its intent; first mismatch stops SDA drive.
// - Start is SDA falling while SCL high; only a host makes it.
// - Stop counts only if SCL went low since the Start.
// - Start and stop interrupt enables add flags in modes lacking them.
// - Restart resets client logic like Start and awaits an address byte.
// - Ninth clock is the ACK slot; receiver pulls SDA low to ACK.
// - Sampled ACK slot level is stored in ack_result.
// - With address or data hold, ACK slot uses ack_value_select.
// - Auto ACK, but NACK when buffer full or overflow already set.
// - ack_time_flag sets after eighth falling edge, only with hold enabled.
// - Four modes: 7 or 10-bit, with or without condition interrupts.
// - First byte after Start compared to own address; match loads and interrupts.
// - In 7-bit mode the read/write bit is ignored in matching.
// - 10-bit high byte is 11110, A9, A8, 0; A9:A8 from own bits 2:1.
// - After 10-bit high ACK, set update flag and hold SCL until rewrite.
// - After 10-bit low byte, set flags regardless; own address write clears update.
// - 10-bit read needs full write match, Restart, then high byte with read.
// - After read request ACK, clear clock_release; stretch_enable stretches after every ACK slot in the receive state.
// - Update flag stretches SCL without clearing clock_release; write releases it.
// - Hold enables clear clock_release after eighth falling edge of matching bytes.
// - Bytes move most significant bit first.
// - Completed byte moves to the buffer and sets the port flag.
// - Mask zeros make address bits don't-care: 7:1 in 7-bit, low byte in 10-bit.
// - General call enabled: ACK all-zero write address and interrupt.
`timescale 1ns/10ps
`default_nettype none

module rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      count;
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			unique case ({push, pop})
				2'b10:   count <= count + 1'b1;
				2'b01:   count <= count - 1'b1;
				default: count <= count;
			endcase
		end
	end
endmodule

module i2c_client_addressing
	import i2c_client_pkg::*;
#(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [1:0] port_mode_select,
	input  wire logic       start_irq_enable,
	input  wire logic       stop_irq_enable,
	input  wire logic       address_hold_enable,
	input  wire logic       data_hold_enable,
	input  wire logic       stretch_enable,
	input  wire logic       general_call_enable,
	input  wire logic       ack_value_select,
	input  wire logic [7:0] address_mask_reg,
	input  wire logic [7:0] own_address_data,
	input  wire logic       own_address_write,
	input  wire logic       clock_release_set,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_write,
	input  wire logic       irq_clear,
	input  wire logic       overflow_clear,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic      [7:0] own_address_reg,
	output logic            clock_release,
	output logic            port_irq_flag,
	output logic            ack_result,
	output logic            ack_time_flag,
	output logic            address_update_flag,
	output logic            buffer_full_flag,
	output logic            receive_overflow_flag,
	output logic            start_seen,
	output logic            stop_seen,
	output logic            read_request,
	output logic            bus_collision
);
	function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own,
	                                    input logic [7:0] mask, input logic use_lsb);
		addr_match = (((rx ^ own) & mask & {7'h7f, use_lsb}) == 8'h00);
	endfunction

	client_state_t state;
	client_state_t next_state;
	logic [1:0]    scl_sync;
	logic [1:0]    sda_sync;
	logic          scl_d;
	logic          sda_d;
	logic [3:0]    bitcnt;
	logic [7:0]    shift_register;
	logic [7:0]    tx_shift;
	logic          scl_low_seen;
	logic          in_slot;
	logic          ack_soft;
	logic          ack_hw;
	logic          tx_first;
	logic          pending_ua;
	logic          addressed10;
	logic          fifo_in_ready;

	// Line sampling
	wire scl_s      = scl_sync[1];
	wire sda_s      = sda_sync[1];
	wire scl_rise   = scl_s & ~scl_d;
	wire scl_fall   = ~scl_s & scl_d;
	wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s & scl_low_seen;
	wire byte_end   = scl_fall & (bitcnt == LAST_DATA_BIT);
	wire slot_end   = scl_fall & (bitcnt == ACK_BIT);

	// Address decode
	wire ten_bit  = port_mode_select[MODE_TEN_BIT];
	wire cond_irq = port_mode_select[MODE_COND_IRQ];
	wire gc_hit   = general_call_enable & (shift_register == GEN_CALL_ADDR);
	wire addr7    = addr_match(shift_register, own_address_reg, address_mask_reg, 1'b0);
	wire hi_hit   = (shift_register[7:3] == TEN_BIT_PREFIX) & (shift_register[2:1] == own_address_reg[2:1])
	              & (~shift_register[0] | addressed10);
	wire lo_hit   = addr_match(shift_register, own_address_reg, address_mask_reg, 1'b1);
	wire addr_hit = gc_hit | (ten_bit ? hi_hit : addr7);

	// Byte completion decode
	wire in_addr   = (state == st_addr);
	wire in_lo     = (state == st_addr_lo);
	wire in_rx     = (state == st_rx);
	wire in_tx     = (state == st_tx);
	wire want_push = byte_end & ((in_addr & addr_hit) | (in_lo & lo_hit) | in_rx);
	wire blocked   = ~fifo_in_ready | receive_overflow_flag;
	wire push      = want_push & ~blocked;
	wire ov_set    = want_push & blocked;
	wire hold      = ((in_addr | in_lo) & address_hold_enable) | (in_rx & data_hold_enable);
	wire hold_hit  = want_push & hold;
	wire lose_arb  = scl_rise & in_tx & ~in_slot & tx_shift[7] & ~sda_s & (bitcnt < LAST_DATA_BIT);
	wire go_ua     = byte_end & ((in_addr & (next_state == st_addr_lo)) | in_lo);
	wire host_ack  = ~ack_result;

	wire irq_set = (start_cond & (cond_irq | start_irq_enable))
	             | (stop_cond & (cond_irq | stop_irq_enable))
	             | push
	             | (byte_end & hold_hit)
	             | (slot_end & pending_ua)
	             | (slot_end & in_tx & (tx_first | host_ack))
	             | (slot_end & in_rx & data_hold_enable & host_ack);
	wire ckp_clr = (byte_end & hold_hit)
	             | (slot_end & tx_first)
	             | (slot_end & in_tx & ~tx_first & host_ack)
	             | (slot_end & in_rx & stretch_enable);

	wire tx_bit_drive = in_tx & ~tx_shift[7] & ~in_slot;
	wire slot_drive   = in_slot & (ack_soft ? ~ack_value_select : ack_hw);
	wire next_sda_oe  = slot_drive | tx_bit_drive;
	wire next_scl_oe  = (~clock_release | address_update_flag) & (scl_oe | ~scl_s);

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	always_comb begin
		next_state = state;
		if (start_cond) begin
			next_state = st_addr;
		end else if (stop_cond) begin
			next_state = st_idle;
		end else if (lose_arb) begin
			next_state = st_ignore;
		end else if (byte_end) begin
			unique case (state)
				st_addr:    next_state = !addr_hit ? st_ignore
				                       : shift_register[0] ? st_tx
				                       : (ten_bit & ~gc_hit) ? st_addr_lo : st_rx;
				st_addr_lo: next_state = lo_hit ? st_rx : st_ignore;
				default:    next_state = state;
			endcase
		end else if (slot_end & in_tx & ~tx_first & ack_result) begin
			next_state = st_ignore;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			scl_sync <= LINE_SYNC_RESET;
			sda_sync <= LINE_SYNC_RESET;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_d    <= scl_s;
			sda_d    <= sda_s;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state        <= st_idle;
			scl_low_seen <= 1'b0;
		end else begin
			state <= next_state;
			if (start_cond) begin
				scl_low_seen <= 1'b0;
			end else if (!scl_s) begin
				scl_low_seen <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bitcnt         <= BITCNT_RESET;
			shift_register <= SHIFT_RESET;
		end else if (start_cond | slot_end) begin
			bitcnt <= BITCNT_RESET;
		end else if (scl_rise) begin
			bitcnt <= bitcnt + 4'h1;
			if (bitcnt < LAST_DATA_BIT) begin
				shift_register <= {shift_register[6:0], sda_s};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tx_shift <= TX_SHIFT_RESET;
		end else if (tx_write) begin
			tx_shift <= tx_data;
		end else if (scl_fall & in_tx & (bitcnt != BITCNT_RESET) & (bitcnt < LAST_DATA_BIT)) begin
			tx_shift <= {tx_shift[6:0], 1'b1};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			in_slot  <= 1'b0;
			ack_soft <= 1'b0;
			ack_hw   <= 1'b0;
			tx_first <= 1'b0;
		end else if (start_cond | slot_end) begin
			in_slot  <= 1'b0;
			tx_first <= 1'b0;
		end else if (byte_end) begin
			in_slot  <= 1'b1;
			ack_soft <= hold_hit;
			ack_hw   <= push;
			tx_first <= in_addr & (next_state == st_tx);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pending_ua  <= 1'b0;
			addressed10 <= 1'b0;
		end else if (stop_cond) begin
			pending_ua  <= 1'b0;
			addressed10 <= 1'b0;
		end else begin
			if (go_ua) begin
				pending_ua <= 1'b1;
			end else if (slot_end | start_cond) begin
				pending_ua <= 1'b0;
			end
			if (byte_end & in_lo & lo_hit) begin
				addressed10 <= 1'b1;
			end else if (byte_end & in_addr & ten_bit & hi_hit & ~shift_register[0]) begin
				addressed10 <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe;
			scl_oe <= next_scl_oe;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			clock_release <= 1'b1;
		end else if (ckp_clr) begin
			clock_release <= 1'b0;
		end else if (clock_release_set | start_cond) begin
			clock_release <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			own_address_reg     <= OWN_ADDR_RESET;
			address_update_flag <= 1'b0;
		end else begin
			if (own_address_write) begin
				own_address_reg <= own_address_data;
			end
			if (slot_end & pending_ua) begin
				address_update_flag <= 1'b1;
			end else if (own_address_write) begin
				address_update_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			port_irq_flag         <= 1'b0;
			receive_overflow_flag <= 1'b0;
			ack_time_flag         <= 1'b0;
			ack_result            <= 1'b1;
		end else begin
			port_irq_flag         <= irq_set | (port_irq_flag & ~irq_clear);
			receive_overflow_flag <= ov_set | (receive_overflow_flag & ~overflow_clear);
			if (byte_end & hold_hit) begin
				ack_time_flag <= 1'b1;
			end else if (slot_end | start_cond) begin
				ack_time_flag <= 1'b0;
			end
			if (scl_rise & (bitcnt == LAST_DATA_BIT)) begin
				ack_result <= sda_s;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			start_seen       <= 1'b0;
			stop_seen        <= 1'b0;
			read_request     <= 1'b0;
			bus_collision    <= 1'b0;
			buffer_full_flag <= 1'b0;
		end else begin
			buffer_full_flag <= ~fifo_in_ready;
			if (start_cond) begin
				start_seen <= 1'b1;
				stop_seen  <= 1'b0;
			end else if (stop_cond) begin
				start_seen <= 1'b0;
				stop_seen  <= 1'b1;
			end
			if (start_cond) begin
				read_request <= 1'b0;
			end else if (byte_end & in_addr & addr_hit) begin
				read_request <= shift_register[0] & ~gc_hit;
			end
			if (lose_arb) begin
				bus_collision <= 1'b1;
			end else if (start_cond) begin
				bus_collision <= 1'b0;
			end
		end
	end

	rx_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (shift_register),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_stretch_waits_low: assert property ($rose(scl_oe) |-> !$past(scl_s))
		else $error("SCL grabbed while high");
	a_release_on_set: assert property ((clock_release && !address_update_flag) |=> !scl_oe)
		else $error("SCL held after release");
	a_arb_loss_drop: assert property ($rose(bus_collision) |-> !sda_oe ##1 !sda_oe)
		else $error("SDA driven after lost arbitration");
	a_stop_needs_low: assert property ($rose(stop_seen) |-> $past(scl_low_seen))
		else $error("Stop without SCL low");
	a_ack_capture: assert property ((scl_rise && bitcnt == LAST_DATA_BIT) |=> ack_result == $past(sda_s))
		else $error("ACK level not stored");
	a_full_nack: assert property ((want_push && blocked && !hold) |=> !sda_oe ##1 !sda_oe)
		else $error("ACK given while blocked");
	a_ack_time_hold: assert property ($rose(ack_time_flag) |-> $past(address_hold_enable || data_hold_enable))
		else $error("ACK time flag without hold");
	a_ua_cleared: assert property ((address_update_flag && own_address_write && !slot_end) |=> !address_update_flag)
		else $error("Update flag not cleared");
	a_restart_resets: assert property (start_cond |=> state == st_addr && bitcnt == BITCNT_RESET)
		else $error("Restart did not reset client");
	a_mismatch_idle: assert property ((byte_end && in_addr && !addr_hit && !start_cond) |=> state == st_ignore)
		else $error("Mismatch not silent");

	c_byte_loaded: cover property (push);
	c_read_request: cover property (in_addr ##[1:400] in_tx);
	c_update_flag: cover property ($rose(address_update_flag));
	c_stop_seen: cover property (stop_cond);
endmodule

`default_nettype wire

// file: test/i2c_host_model.sv
// Purpose: Behavioural I2C host standing on the far side of the client engine
// Assumes: Open-drain lines with pull-ups, resolved by the bench
// Notes:   SCL period 160 ns; waits on a stretched SCL are bounded
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low,
	output logic      hung
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		hung    = 1'b0;
	end

	// Release SCL and honour client stretching
	task automatic free_scl();
		int n;
		scl_low = 1'b0;
		for (n = 0; n < 4000 && scl !== 1'b1; n++) #8;
		if (scl !== 1'b1) hung = 1'b1;
	endtask

	// Data changes only while SCL is low
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		#40;
		free_scl();
		#40;
		r = sda;
		#40;
		scl_low = 1'b1;
		#40;
	endtask

	task automatic start_cond();
		sda_low = 1'b0;
		#40;
		free_scl();
		#40;
		sda_low = 1'b1;
		#40;
		scl_low = 1'b1;
		#40;
	endtask

	task automatic stop_cond();
		sda_low = 1'b1;
		#40;
		free_scl();
		#40;
		sda_low = 1'b0;
		#80;
	endtask

	// SDA dips and returns while SCL stays high
	task automatic dip();
		sda_low = 1'b1;
		#80;
		sda_low = 1'b0;
		#80;
	endtask

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, ack);
	endtask

	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask
endmodule
`default_nettype wire

// file: test/i2c_client_addressing_tb.sv
// Purpose: Self-checking bench for the I2C client engine
// Assumes: Host model drives the bus; software controls are plain ports
// Notes:   Stimulus changes at the falling edge of ref_clk
`timescale 1ns/10ps
`default_nettype none

module i2c_client_addressing_tb import i2c_client_pkg::*; ();
	typedef struct packed {
		logic [1:0] mode;
		logic       sie;
		logic [7:0] mask;
		logic       gce;
		logic [7:0] adr;
		logic       irq_s;
		logic       nack;
	} row_t;
	row_t rows [5] = '{'{2'h0, 1'b0, 8'hff, 1'b0, 8'h84, 1'b0, 1'b0}, '{2'h2, 1'b0, 8'hff, 1'b0, 8'h86, 1'b1, 1'b1},
		'{2'h0, 1'b1, 8'hfd, 1'b0, 8'h86, 1'b1, 1'b0}, '{2'h0, 1'b0, 8'hff, 1'b1, 8'h00, 1'b0, 1'b0},
		'{2'h0, 1'b0, 8'hff, 1'b0, 8'h00, 1'b0, 1'b1}};
	logic       ref_clk = 1'b0, nrst = 1'b0, start_irq_enable = 1'b0, stop_irq_enable = 1'b0;
	logic       address_hold_enable = 1'b0, data_hold_enable = 1'b0, stretch_enable = 1'b0, irq_clear = 1'b0;
	logic       general_call_enable = 1'b0, ack_value_select = 1'b0, own_address_write = 1'b0, tx_write = 1'b0;
	logic       clock_release_set = 1'b0, overflow_clear = 1'b0, rx_ready = 1'b0;
	logic [1:0] port_mode_select = 2'h0;
	logic [7:0] address_mask_reg = 8'hff, own_address_data = 8'h00, tx_data = 8'h00;
	logic       scl_out, scl_oe, sda_out, sda_oe, rx_valid, clock_release, port_irq_flag, ack_result, ack_time_flag;
	logic       address_update_flag, buffer_full_flag, receive_overflow_flag, start_seen, stop_seen, read_request;
	logic       bus_collision, scl_low, sda_low, hung, ack;
	logic [7:0] rx_data, own_address_reg, d;
	wire logic  scl_line, sda_line;
	int         error_cnt = 0, n_compared = 0;

	assign scl_line = ~(scl_low | (scl_oe & ~scl_out));
	assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
	always #4 ref_clk = ~ref_clk;

	i2c_client_addressing #(.FIFO_DEPTH(32)) u_dut (
		.ref_clk, .nrst, .scl_in(scl_line), .scl_out, .scl_oe, .sda_in(sda_line), .sda_out, .sda_oe,
		.port_mode_select, .start_irq_enable, .stop_irq_enable, .address_hold_enable, .data_hold_enable,
		.stretch_enable, .general_call_enable, .ack_value_select, .address_mask_reg, .own_address_data,
		.own_address_write, .clock_release_set, .tx_data, .tx_write, .irq_clear, .overflow_clear, .rx_data,
		.rx_valid, .rx_ready, .own_address_reg, .clock_release, .port_irq_flag, .ack_result, .ack_time_flag,
		.address_update_flag, .buffer_full_flag, .receive_overflow_flag, .start_seen, .stop_seen,
		.read_request, .bus_collision
	);
	i2c_host_model u_host (.scl(scl_line), .sda(sda_line), .scl_low, .sda_low, .hung);

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask

	task automatic await(ref logic s, input logic v);
		for (int n = 0; n < 5000 && s !== v; n++) @(negedge ref_clk);
		if (s !== v) begin
			error_cnt++;
			$display("BAD t=%0t flag wait ran out", $time);
			conclude();
		end
	endtask

	task automatic set_own(input logic [7:0] v);
		@(negedge ref_clk);
		own_address_data = v;
		pulse(own_address_write);
		@(negedge ref_clk);
	endtask

	task automatic drain();
		for (int n = 0; n < 40 && rx_valid === 1'b1; n++) pulse(rx_ready);
	endtask

	task automatic do_reset();
		@(negedge ref_clk);
		nrst = 1'b0;
		repeat (2) @(negedge ref_clk);
		nrst = 1'b1;
		chk({clock_release, ack_result, scl_oe, sda_oe, rx_valid, port_irq_flag, receive_overflow_flag}, 16'h60);
		chk(own_address_reg, 16'h00);
		repeat (4) @(negedge ref_clk);
	endtask

	// Hung bus or runaway run
	always @(negedge ref_clk) if (hung === 1'b1 || $time > 400000) begin
		error_cnt++;
		$display("BAD t=%0t bus wait ran out", $time);
		conclude();
	end

	initial begin
		do_reset();
		u_host.dip();
		repeat (4) @(negedge ref_clk);
		chk({start_seen, stop_seen}, 16'h2);
		set_own(8'h84);
		foreach (rows[k]) begin
			@(negedge ref_clk);
			port_mode_select = rows[k].mode;
			start_irq_enable = rows[k].sie;
			address_mask_reg = rows[k].mask;
			general_call_enable = rows[k].gce;
			u_host.start_cond();
			repeat (4) @(negedge ref_clk);
			chk({start_seen, port_irq_flag}, {1'b1, rows[k].irq_s});
			pulse(irq_clear);
			u_host.wr_byte(rows[k].adr, ack);
			chk({ack, port_irq_flag, rx_valid}, {rows[k].nack, ~rows[k].nack, ~rows[k].nack});
			if (rx_valid === 1'b1)
				chk(rx_data, rows[k].adr);
			drain();
			u_host.stop_cond();
			repeat (4) @(negedge ref_clk);
			chk(stop_seen, 1'b1);
			pulse(irq_clear);
		end
		// Fill the receive queue until it refuses
		u_host.start_cond();
		u_host.wr_byte(8'h84, ack);
		for (int k = 0; k < 31; k++) begin
			u_host.wr_byte(8'(k * 37), ack);
			chk(ack, 1'b0);
		end
		chk({ack_result, buffer_full_flag}, 16'h1);
		u_host.wr_byte(8'h5c, ack);
		chk({ack, ack_result, receive_overflow_flag}, 16'h7);
		u_host.stop_cond();
		for (int k = 0; k < 32; k++) begin
			chk(rx_data, (k == 0) ? 8'h84 : 8'((k - 1) * 37));
			pulse(rx_ready);
		end
		chk(rx_valid, 1'b0);
		pulse(overflow_clear);
		@(negedge ref_clk);
		chk(receive_overflow_flag, 1'b0);
		// Address hold with software NACK
		address_hold_enable = 1'b1;
		ack_value_select = 1'b1;
		u_host.start_cond();
		fork
			u_host.wr_byte(8'h84, ack);
			begin
				await(clock_release, 1'b0);
				repeat (10) @(negedge ref_clk);
				chk({ack_time_flag, scl_oe, scl_line}, 16'h6);
				pulse(clock_release_set);
			end
		join
		chk(ack, 1'b1);
		address_hold_enable = 1'b0;
		u_host.stop_cond();
		drain();
		// Miss, Restart, then read request
		u_host.start_cond();
		u_host.wr_byte(8'h86, ack);
		chk(ack, 1'b1);
		u_host.start_cond();
		fork
			u_host.wr_byte(8'h85, ack);
			begin
				await(clock_release, 1'b0);
				chk(read_request, 1'b1);
				@(negedge ref_clk);
				tx_data = 8'ha6;
				pulse(tx_write);
				pulse(clock_release_set);
			end
		join
		chk(ack, 1'b0);
		u_host.rd_byte(1'b1, d);
		chk(d, 8'ha6);
		chk(bus_collision, 1'b0);
		u_host.stop_cond();
		drain();
		// Lost arbitration on the first transmitted bit
		u_host.start_cond();
		fork
			u_host.wr_byte(8'h85, ack);
			begin
				await(clock_release, 1'b0);
				@(negedge ref_clk);
				tx_data = 8'hff;
				pulse(tx_write);
				pulse(clock_release_set);
			end
		join
		u_host.wr_byte(8'h7f, ack);
		chk({ack, bus_collision, sda_oe}, 16'h6);
		// Restart, data hold with software ACK, stretch after the ACK slot
		data_hold_enable = 1'b1;
		stop_irq_enable = 1'b1;
		ack_value_select = 1'b0;
		u_host.start_cond();
		u_host.wr_byte(8'h84, ack);
		stretch_enable = 1'b1;
		fork
			u_host.wr_byte(8'h3c, ack);
			begin
				await(clock_release, 1'b0);
				chk({ack_time_flag, bus_collision}, 16'h2);
				pulse(irq_clear);
				pulse(clock_release_set);
				await(clock_release, 1'b0);
				repeat (6) @(negedge ref_clk);
				chk({scl_oe, scl_line, port_irq_flag}, 16'h5);
				pulse(clock_release_set);
			end
		join
		chk(ack, 1'b0);
		pulse(irq_clear);
		u_host.stop_cond();
		repeat (4) @(negedge ref_clk);
		chk(port_irq_flag, 1'b1);
		pulse(irq_clear);
		data_hold_enable = 1'b0;
		stretch_enable = 1'b0;
		stop_irq_enable = 1'b0;
		drain();
		// Ten-bit addressing with a missed low byte
		port_mode_select = 2'h3;
		set_own(8'h06);
		u_host.start_cond();
		chk(port_irq_flag, 1'b1);
		fork
			u_host.wr_byte(8'hf6, ack);
			begin
				await(address_update_flag, 1'b1);
				repeat (10) @(negedge ref_clk);
				chk({clock_release, scl_oe}, 16'h3);
				set_own(8'h5a);
				pulse(irq_clear);
			end
		join
		chk({ack, address_update_flag}, 16'h0);
		fork
			u_host.wr_byte(8'h5b, ack);
			begin
				await(address_update_flag, 1'b1);
				chk(port_irq_flag, 1'b1);
				set_own(8'h06);
			end
		join
		chk({ack, address_update_flag, own_address_reg}, 16'h206);
		u_host.stop_cond();
		drain();
		port_mode_select = 2'h0;
		do_reset();
		conclude();
	end
endmodule
`default_nettype wire
